/* src/mcgu_clock_gen.sv */
// clock generation unit: control register, power modes, clock enables
//
// Function
// RL1 - From the oscillator rate the unit makes just two clocks, core and peripheral.
// RL2 - The core clock feeds core and watchdog and runs undivided at the default setting.
// RL3 - Prescale codes 0 to 5 give divide by 1, 2, 4, 8, 16 and 32.
// RL4 - Prescale code 6 divides by 1024 and code 7 by 2048.
// RL5 - A new prescale code takes effect at once with no hidden delay.
// RL6 - The core clock stops while the idle or power-down bit is set.
// RL7 - The watchdog runs from the core clock, so prescale and gating reach it.
// RL8 - The peripheral clock is always the undivided oscillator rate.
// RL9 - Peripherals divide their own clock; this unit never scales it.
// RL10 - The peripheral clock runs in idle and stops only in power-down.
// RL11 - A debug reset command from the test clock side is honoured in idle and power-down and restores normal running.
// RL12 - The debug comparator enable turns the comparators on at 1, off at 0, and is 1 after reset.
// RL13 - With auto recovery set any interrupt forces the prescale to 0; with it clear the prescale is kept.
// RL14 - The clock control register sits at F9h, resets to 10h, bits 7:5 reserved, 4 debug, 3 recovery, 2:0 prescale.
// RL15 - An enabled interrupt in idle clears the idle bit and restarts the core clock.
// RL16 - Power-down stops oscillator and clocks and ends only on pin, low-voltage or debug reset, never watchdog.
`timescale 1ns/100ps
`include "mcgu_params.svh"
module mcgu_clock_gen
	import mcgu_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	output logic            sfr_rd_hit,
	input  wire logic       irq_req,
	input  wire logic       rst_pin_n,
	input  wire logic       lvd_rst,
	input  wire logic       dbg_rst_req,
	input  wire logic       wdt_rst,
	output logic            core_clk_en,
	output logic            peripheral_clock_en,
	output logic            osc_enable,
	output logic            debug_compare_enable,
	output logic            idle_bit,
	output logic            power_down_bit,
	output logic            sup_reset
);
	mcgu_mode_t  mode_ff;
	mcgu_mode_t  nxt_mode;
	mcgu_presc_t presc_ff;
	mcgu_presc_t nxt_presc;
	logic        ar_ff;
	logic        nxt_ar;
	logic        dbg_ff;
	logic        nxt_dbg;
	logic [7:0]  rdata_ff;
	logic [7:0]  nxt_rdata;
	logic        hit_ff;
	logic        nxt_hit;
	logic        periph_ff;
	logic        nxt_periph;
	logic        osc_ff;
	logic        nxt_osc;
	logic        sup_ff;
	logic        nxt_sup;
	logic        dbg_req_d_ff;
	logic        nxt_dbg_req_d;

	logic        pin_n_s;
	logic        lvd_s;
	logic        dbg_req_s;
	logic        ccr_wr;
	logic        pcr_wr;
	logic        ccr_rd;
	logic        pcr_rd;
	logic        sup_rst;
	logic        irq_live;

	mcgu_div_if  div_bus ();

	function automatic logic sfr_hit(input logic [7:0] a,
					 input logic [7:0] target);
		sfr_hit = (a == target);
	endfunction

	// pin and low-voltage levels come from outside the clock domain
	mcgu_sync2 #(
		.WIDTH   (1),
		.RST_VAL (1'h1)
	) u_sync_pin (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (rst_pin_n),
		.sync_out (pin_n_s)
	);

	mcgu_sync2 #(
		.WIDTH   (1),
		.RST_VAL (1'h0)
	) u_sync_lvd (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (lvd_rst),
		.sync_out (lvd_s)
	);

	// debug request is a level toggled high on the test clock side
	mcgu_sync2 #(
		.WIDTH   (1),
		.RST_VAL (1'h0)
	) u_sync_dbg (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (dbg_rst_req),
		.sync_out (dbg_req_s)
	);

	mcgu_core_div u_core_div (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.div     (div_bus.div)
	);

	always_comb begin
		ccr_wr   = sfr_wr && sfr_hit(sfr_addr, `MCGU_CCR_ADDR);
		pcr_wr   = sfr_wr && sfr_hit(sfr_addr, `MCGU_PCR_ADDR);
		ccr_rd   = sfr_rd && sfr_hit(sfr_addr, `MCGU_CCR_ADDR);
		pcr_rd   = sfr_rd && sfr_hit(sfr_addr, `MCGU_PCR_ADDR);
		// no interrupt source runs while in power-down
		irq_live = irq_req && (mode_ff != MCGU_MODE_PDOWN);
		// watchdog has no clock in power-down, so it cannot end it
		sup_rst  = !pin_n_s || lvd_s
			|| (dbg_req_s && !dbg_req_d_ff) // see RL11
			|| (wdt_rst && mode_ff == MCGU_MODE_RUN); // see RL16
	end

	always_comb begin
		nxt_mode      = mode_ff;
		nxt_presc     = presc_ff;
		nxt_ar        = ar_ff;
		nxt_dbg       = dbg_ff;
		nxt_rdata     = `MCGU_ZERO_BYTE;
		nxt_hit       = 1'h0;
		nxt_dbg_req_d = dbg_req_s;

		if (ccr_wr) begin
			nxt_presc = sfr_wdata[`MCGU_PS_MSB:`MCGU_PS_LSB]; // see RL14
			nxt_ar    = sfr_wdata[`MCGU_AR_BIT];
			nxt_dbg   = sfr_wdata[`MCGU_DBG_BIT]; // see RL12
		end
		// hardware force beats a same-cycle software write
		if (irq_live && ar_ff) begin
			nxt_presc = `MCGU_PS_FULL; // see RL13
		end

		case (mode_ff)
			MCGU_MODE_RUN: begin
				if (pcr_wr && sfr_wdata[`MCGU_PD_BIT]) begin
					nxt_mode = MCGU_MODE_PDOWN;
				end else if (pcr_wr && sfr_wdata[`MCGU_IDL_BIT]) begin
					nxt_mode = MCGU_MODE_IDLE;
				end
			end
			MCGU_MODE_IDLE: begin
				if (irq_live) begin
					nxt_mode = MCGU_MODE_RUN; // see RL15
				end else if (pcr_wr && sfr_wdata[`MCGU_PD_BIT]) begin
					nxt_mode = MCGU_MODE_PDOWN;
				end
			end
			MCGU_MODE_PDOWN: begin
				nxt_mode = MCGU_MODE_PDOWN; // see RL16
			end
			default: begin
				nxt_mode = MCGU_MODE_RUN;
			end
		endcase

		if (sup_rst) begin
			nxt_mode  = MCGU_MODE_RUN; // see RL11 see RL16
			nxt_presc = `MCGU_PS_FULL;
			nxt_ar    = `MCGU_AR_RESET;
			nxt_dbg   = `MCGU_DBG_RESET;
		end

		// reserved bits 7:5 read as zero
		if (ccr_rd) begin
			nxt_hit   = 1'h1;
			nxt_rdata = {3'h0, dbg_ff, ar_ff, presc_ff}; // see RL14
		end else if (pcr_rd) begin
			nxt_hit   = 1'h1;
			nxt_rdata[`MCGU_PD_BIT]  = (mode_ff == MCGU_MODE_PDOWN);
			nxt_rdata[`MCGU_IDL_BIT] = (mode_ff == MCGU_MODE_IDLE);
		end

		// the unit makes only the core tick and the peripheral enable
		nxt_periph = (nxt_mode != MCGU_MODE_PDOWN); // see RL1 see RL8 see RL10
		nxt_osc    = (nxt_mode != MCGU_MODE_PDOWN); // see RL16
		nxt_sup    = sup_rst;
	end

	// divider sees the next values so a write changes the rate at once
	always_comb begin
		div_bus.sel     = nxt_presc; // see RL2 see RL5
		div_bus.restart = ccr_wr; // see RL5
		div_bus.gate    = (nxt_mode != MCGU_MODE_RUN); // see RL6
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mode_ff      <= MCGU_MODE_RUN;
			presc_ff     <= `MCGU_PS_FULL;
			ar_ff        <= `MCGU_AR_RESET;
			dbg_ff       <= `MCGU_DBG_RESET;
			rdata_ff     <= `MCGU_ZERO_BYTE;
			hit_ff       <= 1'h0;
			periph_ff    <= 1'h0;
			osc_ff       <= 1'h1;
			sup_ff       <= 1'h0;
			dbg_req_d_ff <= 1'h0;
		end else begin
			mode_ff      <= nxt_mode;
			presc_ff     <= nxt_presc;
			ar_ff        <= nxt_ar;
			dbg_ff       <= nxt_dbg;
			rdata_ff     <= nxt_rdata;
			hit_ff       <= nxt_hit;
			periph_ff    <= nxt_periph;
			osc_ff       <= nxt_osc;
			sup_ff       <= nxt_sup;
			dbg_req_d_ff <= nxt_dbg_req_d;
		end
	end

	// one enable serves core and watchdog; the watchdog divides it further
	assign core_clk_en          = div_bus.tick; // see RL7
	// peripherals apply their own dividers to this undivided enable
	assign peripheral_clock_en        = periph_ff; // see RL9
	assign osc_enable           = osc_ff;
	assign debug_compare_enable = dbg_ff; // see RL12
	assign idle_bit             = (mode_ff == MCGU_MODE_IDLE);
	assign power_down_bit       = (mode_ff == MCGU_MODE_PDOWN);
	assign sfr_rdata            = rdata_ff;
	assign sfr_rd_hit           = hit_ff;
	assign sup_reset            = sup_ff;
endmodule

/* src/mcgu_params.svh */
// constants of the clock generation unit: addresses, fields, reset values
`ifndef MCGU_PARAMS_SVH
`define MCGU_PARAMS_SVH

`define MCGU_CCR_ADDR      8'hF9
`define MCGU_PCR_ADDR      8'h87
`define MCGU_CCR_RESET     8'h10
`define MCGU_ZERO_BYTE     8'h00

`define MCGU_DBG_BIT       4
`define MCGU_AR_BIT        3
`define MCGU_PS_MSB        2
`define MCGU_PS_LSB        0
`define MCGU_PD_BIT        1
`define MCGU_IDL_BIT       0

`define MCGU_PS_FULL       3'h0
`define MCGU_DBG_RESET     1'h1
`define MCGU_AR_RESET      1'h0

`define MCGU_CNT_W         11
`define MCGU_TC_DIV1       11'h000
`define MCGU_TC_DIV2       11'h001
`define MCGU_TC_DIV4       11'h003
`define MCGU_TC_DIV8       11'h007
`define MCGU_TC_DIV16      11'h00F
`define MCGU_TC_DIV32      11'h01F
`define MCGU_TC_DIV1024    11'h3FF
`define MCGU_TC_DIV2048    11'h7FF
`define MCGU_CNT_ZERO      11'h000
`define MCGU_CNT_ONE       11'h001

`endif

/* src/mcgu_pkg.sv */
// types shared by the clock generation unit modules
package mcgu_pkg;

	typedef enum logic [2:0] {
		MCGU_MODE_RUN   = 3'b001,
		MCGU_MODE_IDLE  = 3'b010,
		MCGU_MODE_PDOWN = 3'b100
	} mcgu_mode_t;

	typedef logic [2:0] mcgu_presc_t;

endpackage

/* src/mcgu_div_if.sv */
// carrier between the control logic and the core clock divider
`timescale 1ns/100ps
interface mcgu_div_if;
	import mcgu_pkg::*;

	mcgu_presc_t sel;
	logic        gate;
	logic        restart;
	logic        tick;

	modport ctrl (
		output sel,
		output gate,
		output restart,
		input  tick
	);

	modport div (
		input  sel,
		input  gate,
		input  restart,
		output tick
	);
endinterface

/* src/mcgu_sync2.sv */
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
module mcgu_sync2 #(
	parameter int         WIDTH   = 1,
	parameter logic [0:0] RST_VAL = 1'h0
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output wire logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] stable_ff;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_ff   <= {WIDTH{RST_VAL}};
			stable_ff <= {WIDTH{RST_VAL}};
		end else begin
			meta_ff   <= async_in;
			stable_ff <= meta_ff;
		end
	end

	assign sync_out = stable_ff;
endmodule

/* src/mcgu_core_div.sv */
// core clock prescaler: one-cycle enable pulse at the selected rate
`timescale 1ns/100ps
`include "mcgu_params.svh"
module mcgu_core_div
	import mcgu_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	mcgu_div_if.div   div
);
	logic [`MCGU_CNT_W-1:0] cnt_ff;
	logic [`MCGU_CNT_W-1:0] nxt_cnt;
	mcgu_presc_t            sel_ff;
	mcgu_presc_t            nxt_sel;
	logic                   tick_ff;
	logic                   nxt_tick;
	logic [`MCGU_CNT_W-1:0] cur;
	logic [`MCGU_CNT_W-1:0] tc;

	function automatic logic [`MCGU_CNT_W-1:0] div_term(input mcgu_presc_t c);
		case (c)
			3'h0:    div_term = `MCGU_TC_DIV1;
			3'h1:    div_term = `MCGU_TC_DIV2;
			3'h2:    div_term = `MCGU_TC_DIV4;
			3'h3:    div_term = `MCGU_TC_DIV8;
			3'h4:    div_term = `MCGU_TC_DIV16;
			3'h5:    div_term = `MCGU_TC_DIV32;
			3'h6:    div_term = `MCGU_TC_DIV1024;
			default: div_term = `MCGU_TC_DIV2048;
		endcase
	endfunction

	always_comb begin
		// restart the count on a new code so the new rate is live at once
		// a rewrite of the same code restarts too, so every write has one phase
		cur      = (div.restart || div.sel != sel_ff) ? `MCGU_CNT_ZERO
			: cnt_ff; // see RL5
		tc       = div_term(div.sel); // see RL3 see RL4
		nxt_sel  = div.sel;
		nxt_tick = !div.gate && (cur == `MCGU_CNT_ZERO); // see RL6
		if (div.gate) begin
			nxt_cnt = cur;
		end else if (cur >= tc) begin
			nxt_cnt = `MCGU_CNT_ZERO;
		end else begin
			nxt_cnt = cur + `MCGU_CNT_ONE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_ff  <= `MCGU_CNT_ZERO;
			sel_ff  <= `MCGU_PS_FULL;
			tick_ff <= 1'h0;
		end else begin
			cnt_ff  <= nxt_cnt;
			sel_ff  <= nxt_sel;
			tick_ff <= nxt_tick;
		end
	end

	assign div.tick = tick_ff;
endmodule

/* verification/mcgu_clock_gen_checker.sv */
// port assertions of the clock generation unit
`timescale 1ns/100ps
module mcgu_clock_gen_checker (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_rd_hit,
	input wire logic       irq_req,
	input wire logic       dbg_rst_req,
	input wire logic       wdt_rst,
	input wire logic       core_clk_en,
	input wire logic       peripheral_clock_en,
	input wire logic       osc_enable,
	input wire logic       debug_compare_enable,
	input wire logic       idle_bit,
	input wire logic       power_down_bit,
	input wire logic       sup_reset
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic low_pwr;
	assign low_pwr = idle_bit || power_down_bit;
	sequence s_ps(c);
		sfr_wr && sfr_addr == 8'hF9 && sfr_wdata[2:0] == c && !low_pwr
			&& !irq_req;
	endsequence
	// nothing that could restart or gate the divider
	sequence s_calm;
		!sfr_wr && !irq_req && !low_pwr && !sup_reset;
	endsequence
	a_div_one: assert property (s_ps(3'h0) ##1 s_calm[*3] |-> core_clk_en
		&& $past(core_clk_en) && $past(core_clk_en, 2))
		else $error("core enable not every cycle");
	a_div_two: assert property (s_ps(3'h1) ##1 s_calm[*3] |-> core_clk_en
		&& !$past(core_clk_en) && $past(core_clk_en, 2))
		else $error("core enable not every second cycle");
	a_core_gate: assert property (low_pwr |-> !core_clk_en)
		else $error("core enable while gated");
	a_periph_run: assert property (!$past(sys_rst) |->
		peripheral_clock_en == !power_down_bit && osc_enable == !power_down_bit)
		else $error("peripheral clock or oscillator wrong");
	a_read_ccr: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'hF9
		|=> sfr_rd_hit && sfr_rdata[7:5] == 3'h0
		&& sfr_rdata[4] == debug_compare_enable)
		else $error("control register read wrong");
	a_read_miss: assert property (sfr_rd && sfr_addr != 8'hF9
		&& sfr_addr != 8'h87 |=> !sfr_rd_hit && sfr_rdata == 8'h00)
		else $error("unmapped read answered");
	a_idle_exit: assert property (idle_bit && irq_req && !sfr_wr
		|=> !idle_bit && !power_down_bit)
		else $error("idle not left on interrupt");
	a_pd_entry: assert property (sfr_wr && sfr_addr == 8'h87
		&& sfr_wdata[1] && !low_pwr && !sup_reset
		|=> power_down_bit && !peripheral_clock_en && !osc_enable)
		else $error("power-down not entered");
	a_pd_hold: assert property (power_down_bit && (irq_req || wdt_rst)
		&& !sup_reset |=> power_down_bit)
		else $error("power-down left without supervisor reset");
	a_dbg_exit: assert property (power_down_bit && $rose(dbg_rst_req)
		|-> ##[2:4] sup_reset && !power_down_bit)
		else $error("debug reset did not end power-down");
endmodule

bind mcgu_clock_gen mcgu_clock_gen_checker u_chk (.sys_clk(sys_clk),
	.sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.sfr_rd_hit(sfr_rd_hit), .irq_req(irq_req), .dbg_rst_req(dbg_rst_req),
	.wdt_rst(wdt_rst), .core_clk_en(core_clk_en),
	.peripheral_clock_en(peripheral_clock_en), .osc_enable(osc_enable),
	.debug_compare_enable(debug_compare_enable), .idle_bit(idle_bit),
	.power_down_bit(power_down_bit), .sup_reset(sup_reset));

/* verification/mcgu_sup_model.sv */
// reset sources outside the unit: reset pin, low-voltage detector, debug port
`timescale 1ns/100ps
module mcgu_sup_model (
	input  wire logic       sys_clk,
	input  wire logic       go,
	input  wire logic [1:0] kind,
	output logic            rst_pin_n,
	output logic            lvd_rst,
	output logic            dbg_rst_req
);
	initial begin
		rst_pin_n = 1'h1;
		lvd_rst = 1'h0;
		dbg_rst_req = 1'h0;
	end
	// off the clock edge on purpose: these come from other domains
	always @(posedge go) begin
		#3;
		case (kind)
			2'h0: rst_pin_n = 1'h0;
			2'h1: lvd_rst = 1'h1;
			default: dbg_rst_req = 1'h1;
		endcase
		repeat (6) @(posedge sys_clk);
		#3;
		rst_pin_n = 1'h1;
		lvd_rst = 1'h0;
		dbg_rst_req = 1'h0;
	end
endmodule

/* verification/test_mcgu_clock_gen.sv */
// self-checking bench of the clock generation unit
`timescale 1ns/100ps
module test_mcgu_clock_gen;
	logic       sys_clk;
	logic       sys_rst;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_rdata;
	logic       sfr_rd_hit;
	logic       irq_req;
	logic       rst_pin_n;
	logic       lvd_rst;
	logic       dbg_rst_req;
	logic       wdt_rst;
	logic       core_clk_en;
	logic       peripheral_clock_en;
	logic       osc_enable;
	logic       debug_compare_enable;
	logic       idle_bit;
	logic       power_down_bit;
	logic       sup_reset;
	logic       go;
	logic [1:0] kind;
	logic [7:0] ccr;
	logic [7:0] d;
	int         num_errors;
	int         cmp_count;
	int         seed;
	int         n;

	mcgu_clock_gen u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_rd_hit(sfr_rd_hit),
		.irq_req(irq_req), .rst_pin_n(rst_pin_n), .lvd_rst(lvd_rst),
		.dbg_rst_req(dbg_rst_req), .wdt_rst(wdt_rst),
		.core_clk_en(core_clk_en), .peripheral_clock_en(peripheral_clock_en),
		.osc_enable(osc_enable), .debug_compare_enable(debug_compare_enable),
		.idle_bit(idle_bit), .power_down_bit(power_down_bit),
		.sup_reset(sup_reset));
	mcgu_sup_model u_sup (.sys_clk(sys_clk), .go(go), .kind(kind),
		.rst_pin_n(rst_pin_n), .lvd_rst(lvd_rst), .dbg_rst_req(dbg_rst_req));

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic int div_of(input logic [2:0] c);
		return c == 3'h6 ? 1024 : c == 3'h7 ? 2048 : 1 << c;
	endfunction

	task automatic summarize;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// n counts the falling edges spent waiting
	task automatic await(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == lim) begin
			num_errors++;
			summarize;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'h1;
		@(negedge sys_clk);
		sfr_wr = 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_rd = 1'h1;
		@(negedge sys_clk);
		sfr_rd = 1'h0;
		chk(12'(sfr_rdata), 12'(e));
	endtask

	task automatic tick(input logic i, input logic w);
		@(negedge sys_clk);
		irq_req = i;
		wdt_rst = w;
		@(negedge sys_clk);
		irq_req = 1'h0;
		wdt_rst = 1'h0;
	endtask

	// fire one supervisor source, then wait for the reset to pass
	task automatic sup_fire(input logic [1:0] k);
		@(negedge sys_clk);
		kind = k;
		go = 1'h1;
		@(negedge sys_clk);
		go = 1'h0;
		await(sup_reset, 1'h1, 40);
		await(sup_reset, 1'h0, 40);
		rd(8'hF9, 8'h10);
	endtask

	initial begin
		{sfr_addr, sfr_wdata, sfr_wr, sfr_rd, irq_req, wdt_rst} = '0;
		{go, kind, num_errors, cmp_count} = '0;
		seed = 47;
		sys_rst = 1'h1;
		repeat (8) @(negedge sys_clk);
		sys_rst = 1'h0;
		chk(12'(debug_compare_enable), 12'h001);
		rd(8'hF9, 8'h10);
		rd(8'h87, 8'h00);
		d = 8'($random(seed));
		rd((d == 8'hF9 || d == 8'h87) ? 8'h00 : d, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(8'hF9, 8'h10 | 8'(c));
			rd(8'hF9, 8'h10 | 8'(c));
			await(core_clk_en, 1'h1, 4100);
			@(negedge sys_clk);
			await(core_clk_en, 1'h1, 4100);
			chk(12'(n + 1), 12'(div_of(3'(c))));
			chk(12'(peripheral_clock_en), 12'h001);
		end
		ccr = 8'h17;
		repeat (30) begin
			d = 8'($random(seed));
			if (d[7]) begin
				wr(8'hF9, d);
				ccr = d & 8'h1F;
				chk(12'(debug_compare_enable), 12'(d[4]));
			end else begin
				tick(1'h1, 1'h0);
				if (ccr[3])
					ccr[2:0] = 3'h0;
			end
			rd(8'hF9, ccr);
		end
		wr(8'h87, 8'h01);
		chk(12'({idle_bit, peripheral_clock_en}), 12'h003);
		tick(1'h0, 1'h1);
		tick(1'h0, 1'h0);
		chk(12'(idle_bit), 12'h001);
		tick(1'h1, 1'h0);
		chk(12'(idle_bit), 12'h000);
		await(core_clk_en, 1'h1, 4100);
		for (int k = 0; k < 3; k++) begin
			wr(8'hF9, 8'h0B);
			wr(8'h87, 8'h02);
			chk(12'({power_down_bit, peripheral_clock_en, osc_enable}), 12'h004);
			tick(1'h1, 1'h1);
			chk(12'(power_down_bit), 12'h001);
			sup_fire(2'(k));
			chk(12'(power_down_bit), 12'h000);
		end
		wr(8'hF9, 8'h0B);
		tick(1'h0, 1'h1);
		await(sup_reset, 1'h1, 40);
		await(sup_reset, 1'h0, 40);
		rd(8'hF9, 8'h10);
		summarize;
	end
endmodule
